// ===== src/psmc_top.sv
// Power save controller: mode select, write unlock and clock gating.
`timescale 1ns/1ps
// Operation
// [R1] Software stop halts oscillator and PLL so no clock reaches CPU or peripherals.
// [R2] On stop entry the PLL output is cut in the same cycle as the oscillator.
// [R3] In PLL mode, execution waits after stop release for the time base interval.
// [R4] In direct mode the outside clock source pulls the oscillator input low in stop.
// [R5] In direct mode, execution also waits after stop release for the interval.
// [R6] Halt gates the CPU clock, idle gates CPU and peripheral clocks, direct never uses PLL.
// [R7] The mode select register takes effect only once the standby request bit is set.
// [R8] Mode select bit 0 picks idle (0) or stop (1) and bits 7 to 1 read zero.
// [R9] The mode select register takes stores and single-bit set, clear or invert.
// [R10] A power control write is kept only when an unlock command write came first.
// [R11] The unlock command register takes byte writes and reads undefined.
// [R12] Any 8-bit code written to the unlock command arms the unlock.
// [R13] The standby request bit clears itself when standby is released.
// [R14] An NMI edge releases standby only when its wake-disable bit is 0.
// [R15] The unlock covers only the very next write; any other write cancels it.
module psmc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        direct_mode,
  input  wire logic        ext_clock,
  input  wire logic        halt_req,
  input  wire logic        nmi_pin,
  input  wire logic        irq_wake,
  output logic             osc_en,
  output logic             pll_en,
  output logic             periph_clk_en,
  output logic             cpu_clk_en,
  output logic             exec_hold
);

  psmc_pkg::psmc_req_s   req;
  psmc_pkg::psmc_state_e state_r;
  psmc_pkg::psmc_gate_s  gate_nxt;
  psmc_pkg::psmc_gate_s  gate_r;

  logic [7:0] mode_sel_r;
  logic [7:0] power_ctrl_r;
  logic       unlock_armed_r;
  logic       tb_start;
  logic       tb_done;
  logic       nmi_s1_r;
  logic       nmi_s2_r;
  logic       nmi_s3_r;
  logic       nmi_lvl_r;
  logic       nmi_edge;
  logic       irq_s1_r;
  logic       irq_s2_r;
  logic       irq_s3_r;
  logic       irq_lvl_r;
  logic       halt_s1_r;
  logic       halt_s2_r;
  logic       halt_s3_r;
  logic       halt_lvl_r;
  logic       wake;
  logic       standby_release;
  logic       wr_unlock;
  logic       wr_power;
  logic       wr_mode;
  logic       wr_bitop;
  logic       byte0_en;
  logic       standby_req;
  logic [1:0] bit_op;
  logic [2:0] bit_idx;
  logic [7:0] power_wdata;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a[31:2] == b[31:2]);
  endfunction : hit

  // Power control sits in byte lane 1 of its word, where reads return it.
  function automatic logic [7:0] lane(input logic [31:0] d);
    lane = d[15:8];
  endfunction : lane

  psmc_apb_if u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .pslverr (pslverr),
    .req     (req)
  );

  psmc_time_base u_tb (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tb_start),
    .done    (tb_done)
  );

  assign byte0_en  = (pstrb != 4'h0);
  assign wr_unlock = req.wr && byte0_en &&
                     hit(req.addr, psmc_pkg::UNLOCK_CMD_ADDR) &&
                     (req.addr[1:0] == psmc_pkg::UNLOCK_CMD_ADDR[1:0]);
  assign wr_power  = req.wr && (req.addr == psmc_pkg::POWER_CTRL_ADDR);
  assign wr_mode   = req.wr && hit(req.addr, psmc_pkg::MODE_SEL_ADDR);
  assign wr_bitop  = req.wr && hit(req.addr, psmc_pkg::BIT_OP_ADDR);
  assign bit_op    = req.wdata[9:8];
  assign bit_idx   = req.wdata[2:0];
  assign standby_req = power_ctrl_r[psmc_pkg::STANDBY_REQ_BIT];
  assign power_wdata = lane(req.wdata);

  // Unlock arms on any code and is spent by the very next write of any kind.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_armed_r <= 1'b0;
    end else if (wr_unlock) begin
      unlock_armed_r <= 1'b1; // [R12] [R11]
    end else if (req.wr) begin
      unlock_armed_r <= 1'b0; // [R15]
    end
  end

  // Mode select: byte store, or single-bit set, clear, invert on bit 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sel_r <= psmc_pkg::MODE_SEL_RESET;
    end else if (wr_mode && byte0_en) begin
      mode_sel_r <= {7'h00, req.wdata[psmc_pkg::STOP_SEL_BIT]}; // [R8] [R9]
    end else if (wr_bitop && bit_idx == 3'(psmc_pkg::STOP_SEL_BIT)) begin
      unique case (bit_op) // [R9]
        psmc_pkg::BITOP_SET:    mode_sel_r[0] <= 1'b1;
        psmc_pkg::BITOP_CLEAR:  mode_sel_r[0] <= 1'b0;
        psmc_pkg::BITOP_INVERT: mode_sel_r[0] <= ~mode_sel_r[0];
        default:                mode_sel_r[0] <= mode_sel_r[0];
      endcase
    end
  end

  // Power control: guarded writes; release clears the request bit and wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ctrl_r <= psmc_pkg::POWER_CTRL_RESET;
    end else begin
      if (wr_power && unlock_armed_r) begin
        power_ctrl_r[psmc_pkg::NMI_WAKE_BIT] <= // [R10]
          power_wdata[psmc_pkg::NMI_WAKE_BIT];
        power_ctrl_r[psmc_pkg::IRQ_WAKE_BIT] <=
          power_wdata[psmc_pkg::IRQ_WAKE_BIT];
        power_ctrl_r[psmc_pkg::STANDBY_REQ_BIT] <=
          power_wdata[psmc_pkg::STANDBY_REQ_BIT];
      end
      if (standby_release) begin
        power_ctrl_r[psmc_pkg::STANDBY_REQ_BIT] <= 1'b0; // [R13]
      end
    end
  end

  // Each pin passes three flops; a change counts when the last two agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s1_r  <= 1'b0;
      nmi_s2_r  <= 1'b0;
      nmi_s3_r  <= 1'b0;
      nmi_lvl_r <= 1'b0;
    end else begin
      nmi_s1_r <= nmi_pin;
      nmi_s2_r <= nmi_s1_r;
      nmi_s3_r <= nmi_s2_r;
      if (nmi_s2_r == nmi_s3_r) nmi_lvl_r <= nmi_s3_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_r  <= 1'b0;
      irq_s2_r  <= 1'b0;
      irq_s3_r  <= 1'b0;
      irq_lvl_r <= 1'b0;
    end else begin
      irq_s1_r <= irq_wake;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
      if (irq_s2_r == irq_s3_r) irq_lvl_r <= irq_s3_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_s1_r  <= 1'b0;
      halt_s2_r  <= 1'b0;
      halt_s3_r  <= 1'b0;
      halt_lvl_r <= 1'b0;
    end else begin
      halt_s1_r <= halt_req;
      halt_s2_r <= halt_s1_r;
      halt_s3_r <= halt_s2_r;
      if (halt_s2_r == halt_s3_r) halt_lvl_r <= halt_s3_r;
    end
  end

  assign nmi_edge = (nmi_s2_r == nmi_s3_r) && nmi_s3_r && !nmi_lvl_r;
  assign wake = (nmi_edge && !power_ctrl_r[psmc_pkg::NMI_WAKE_BIT]) || // [R14]
                (irq_lvl_r && !power_ctrl_r[psmc_pkg::IRQ_WAKE_BIT]);
  assign standby_release = wake &&
    (state_r == psmc_pkg::PSMC_IDLE || state_r == psmc_pkg::PSMC_STOP);
  assign tb_start = standby_release && (state_r == psmc_pkg::PSMC_STOP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= psmc_pkg::PSMC_RUN;
    end else begin
      unique case (state_r)
        psmc_pkg::PSMC_RUN: begin
          if (standby_req) begin // [R7]
            state_r <= mode_sel_r[psmc_pkg::STOP_SEL_BIT] ?
                       psmc_pkg::PSMC_STOP : psmc_pkg::PSMC_IDLE;
          end
        end
        psmc_pkg::PSMC_IDLE: begin
          if (wake) state_r <= psmc_pkg::PSMC_RUN;
        end
        psmc_pkg::PSMC_STOP: begin
          if (wake) state_r <= psmc_pkg::PSMC_WAKE_WAIT; // [R3] [R5]
        end
        psmc_pkg::PSMC_WAKE_WAIT: begin
          if (tb_done) state_r <= psmc_pkg::PSMC_RUN;
        end
      endcase
    end
  end

  // Clock enables per mode; oscillator and PLL drop together in stop.
  always_comb begin
    gate_nxt = '{osc_en: 1'b1, pll_en: 1'b1,
                 periph_clk_en: 1'b1, cpu_clk_en: 1'b1};
    unique case (state_r)
      psmc_pkg::PSMC_RUN: begin
        gate_nxt.cpu_clk_en = !halt_lvl_r; // [R6]
      end
      psmc_pkg::PSMC_IDLE: begin
        gate_nxt.periph_clk_en = 1'b0; // [R6]
        gate_nxt.cpu_clk_en    = 1'b0;
      end
      psmc_pkg::PSMC_STOP: begin
        gate_nxt = '0; // [R1] [R2]
      end
      psmc_pkg::PSMC_WAKE_WAIT: begin
        gate_nxt.periph_clk_en = 1'b0;
        gate_nxt.cpu_clk_en    = 1'b0;
      end
    endcase
    if (direct_mode) gate_nxt.pll_en = 1'b0; // [R6] [R4]
    if (ext_clock || direct_mode) gate_nxt.osc_en = 1'b0; // [R6]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= '0;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  assign osc_en        = gate_r.osc_en;
  assign pll_en        = gate_r.pll_en;
  assign periph_clk_en = gate_r.periph_clk_en;
  assign cpu_clk_en    = gate_r.cpu_clk_en;
  assign exec_hold     = !gate_r.cpu_clk_en;

  // Read mux; unlock reads give a fixed filler value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit(paddr, psmc_pkg::MODE_SEL_ADDR)) begin
        prdata <= {24'h00_0000, mode_sel_r};
      end else if (hit(paddr, psmc_pkg::POWER_CTRL_ADDR)) begin
        prdata <= {16'h0000, power_ctrl_r, psmc_pkg::UNDEF_READ_VALUE};
      end else if (hit(paddr, psmc_pkg::STATUS_ADDR)) begin
        prdata <= {30'h0000_0000, 2'(state_r)};
      end else begin
        prdata <= 32'h0000_0000; // [R11]
      end
    end
  end

endmodule : psmc_top

// ===== src/psmc_pkg.sv
// Package with register map, field positions and shared types of the power save controller.
package psmc_pkg;

  // Register byte addresses within the APB window (low 32 bits of the map).
  localparam logic [31:0] UNLOCK_CMD_ADDR = 32'hffff_f1fc;
  localparam logic [31:0] POWER_CTRL_ADDR = 32'hffff_f1fe;
  localparam logic [31:0] MODE_SEL_ADDR   = 32'hffff_f820;
  localparam logic [31:0] BIT_OP_ADDR     = 32'hffff_f828;
  localparam logic [31:0] STATUS_ADDR     = 32'hffff_f82c;

  // Field positions.
  localparam int STOP_SEL_BIT    = 0;
  localparam int STANDBY_REQ_BIT = 1;
  localparam int IRQ_WAKE_BIT    = 4;
  localparam int NMI_WAKE_BIT    = 5;

  // Reset values.
  localparam logic [7:0] MODE_SEL_RESET   = 8'h00;
  localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
  localparam logic [7:0] UNDEF_READ_VALUE = 8'h00;

  // Time base counter interval after stop release, in cycles of pclk.
  localparam int TIME_BASE_CYCLES = 16384;
  localparam int TB_WIDTH         = 15;

  // Single-bit operation codes carried in bits 9:8 of a bit-op write.
  localparam logic [1:0] BITOP_SET    = 2'h1;
  localparam logic [1:0] BITOP_CLEAR  = 2'h2;
  localparam logic [1:0] BITOP_INVERT = 2'h3;

  typedef enum logic [1:0] {
    PSMC_RUN,
    PSMC_IDLE,
    PSMC_STOP,
    PSMC_WAKE_WAIT
  } psmc_state_e;

  typedef struct packed {
    logic osc_en;
    logic pll_en;
    logic periph_clk_en;
    logic cpu_clk_en;
  } psmc_gate_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } psmc_req_s;

endpackage : psmc_pkg

// ===== src/psmc_apb_if.sv
// APB slave front end that turns bus transfers into one-cycle requests.
`timescale 1ns/1ps
module psmc_apb_if (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output psmc_pkg::psmc_req_s    req
);

  // Zero wait states: every access completes in its first access cycle.
  always_comb begin
    pready        = 1'b1;
    pslverr       = 1'b0;
    req.wr        = psel & penable & pwrite;
    req.rd        = psel & penable & ~pwrite;
    req.addr      = paddr;
    req.wdata     = pwdata;
  end

endmodule : psmc_apb_if

// ===== src/psmc_time_base.sv
// Time base counter that measures the interval after a stop release.
`timescale 1ns/1ps
module psmc_time_base (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      done
);

  localparam logic [psmc_pkg::TB_WIDTH-1:0] LAST =
    psmc_pkg::TB_WIDTH'(psmc_pkg::TIME_BASE_CYCLES - 1);

  logic [psmc_pkg::TB_WIDTH-1:0] count_r;
  logic                          busy_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
      busy_r  <= 1'b0;
    end else if (start) begin
      count_r <= '0;
      busy_r  <= 1'b1;
    end else if (busy_r) begin
      if (count_r == LAST) begin
        busy_r <= 1'b0;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  assign done = busy_r && (count_r == LAST);

endmodule : psmc_time_base

// ===== tb/psmc_monitor.sv
// Port checker of the power save controller.
`timescale 1ns/1ps
module psmc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        direct_mode,
  input wire logic        ext_clock,
  input wire logic        halt_req,
  input wire logic        osc_en,
  input wire logic        pll_en,
  input wire logic        periph_clk_en,
  input wire logic        cpu_clk_en,
  input wire logic        exec_hold
);
  localparam int HOLD_MIN = 16380;
  localparam int HOLD_MAX = 16390;
  logic [15:0] hold_cnt_r;
  logic        stop_seen_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts the wake wait, while the oscillator runs but the CPU is held.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_cnt_r <= 16'h0000;
    else if (exec_hold && osc_en) hold_cnt_r <= hold_cnt_r + 16'h0001;
    else hold_cnt_r <= 16'h0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stop_seen_r <= 1'b0;
    else if ($fell(osc_en)) stop_seen_r <= 1'b1;
    else if (cpu_clk_en) stop_seen_r <= 1'b0;
  end
  chk_zero_wait: assert property (
    psel && penable |-> pready && !pslverr) else $error("bus answer wrong");
  chk_stop_all_off: assert property (
    !osc_en && !direct_mode && !ext_clock && !$past(ext_clock)
    |-> !pll_en && !periph_clk_en && !cpu_clk_en) else $error("stop leak");
  chk_stop_cpu_off: assert property (
    $fell(osc_en) && !ext_clock && !direct_mode |-> !cpu_clk_en)
    else $error("osc stopped while cpu runs");
  chk_pll_with_osc: assert property (
    $fell(pll_en) && !direct_mode && !ext_clock |-> $fell(osc_en))
    else $error("pll stop not with osc");
  chk_wake_wait: assert property (
    $rose(cpu_clk_en) && stop_seen_r
    |-> hold_cnt_r >= HOLD_MIN && hold_cnt_r <= HOLD_MAX)
    else $error("wake wait length wrong");
  chk_hold_mirror: assert property (
    exec_hold == !cpu_clk_en) else $error("hold not tied to cpu clock");
  chk_cpu_periph: assert property (
    cpu_clk_en |-> periph_clk_en) else $error("cpu runs without periph");
  chk_direct_pll: assert property (
    direct_mode |=> !pll_en) else $error("pll used in direct mode");
  chk_halt_gate: assert property (
    halt_req [*6] |-> !cpu_clk_en && $stable(periph_clk_en))
    else $error("halt did not gate cpu");
  chk_mode_read: assert property (
    psel && !penable && !pwrite && paddr == psmc_pkg::MODE_SEL_ADDR
    |=> prdata[7:1] == 7'h00) else $error("mode select upper bits");
endmodule : psmc_monitor

// ===== tb/tb.sv
// Self-checking testbench of the power save controller.
`timescale 1ns/1ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, direct_mode, ext_clock, halt_req;
  logic        nmi_pin, irq_wake, osc_en, pll_en;
  logic        periph_clk_en, cpu_clk_en, exec_hold;
  int          err_count, num_checks, n;
  logic [31:0] d;
  psmc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .direct_mode(direct_mode), .ext_clock(ext_clock),
    .halt_req(halt_req), .nmi_pin(nmi_pin), .irq_wake(irq_wake),
    .osc_en(osc_en), .pll_en(pll_en), .periph_clk_en(periph_clk_en),
    .cpu_clk_en(cpu_clk_en), .exec_hold(exec_hold));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic prot(input logic [7:0] c, input logic [7:0] v);
    apb(1'b1, psmc_pkg::UNLOCK_CMD_ADDR, {24'h00_0000, c}, 4'h1);
    apb(1'b1, psmc_pkg::POWER_CTRL_ADDR, {16'h0000, v, 8'h00}, 4'h2);
    repeat (4) @(posedge pclk);
  endtask : prot
  function automatic logic [31:0] gates();
    return {28'h000_0000, osc_en, pll_en, periph_clk_en, cpu_clk_en};
  endfunction : gates
  // Pulses a wake source and counts cycles until execution resumes.
  task automatic wake(input logic nmi);
    n = 0;
    if (nmi) nmi_pin <= 1'b1;
    else irq_wake <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n == 6) begin
        nmi_pin  <= 1'b0;
        irq_wake <= 1'b0;
      end
    end while (exec_hold !== 1'b0 || n < 6);
  endtask : wake
  task automatic bitop(input logic [1:0] op, input logic [31:0] exp);
    apb(1'b1, psmc_pkg::BIT_OP_ADDR, {22'h00_0000, op, 8'h00}, 4'h3);
    apb(1'b0, psmc_pkg::MODE_SEL_ADDR, 32'h0000_0000, 4'h0);
    check(d, exp);
  endtask : bitop
  task automatic t_mode();
    apb(1'b0, psmc_pkg::UNLOCK_CMD_ADDR, 32'h0000_0000, 4'h0);
    check(d, 32'h0000_0000);
    apb(1'b1, psmc_pkg::MODE_SEL_ADDR, 32'h0000_00ff, 4'h1);
    apb(1'b0, psmc_pkg::MODE_SEL_ADDR, 32'h0000_0000, 4'h0);
    check(d, 32'h0000_0001);
    check(gates(), 32'h0000_000f);
    bitop(psmc_pkg::BITOP_CLEAR, 32'h0000_0000);
    bitop(psmc_pkg::BITOP_SET, 32'h0000_0001);
    bitop(psmc_pkg::BITOP_INVERT, 32'h0000_0000);
    apb(1'b1, psmc_pkg::BIT_OP_ADDR, {22'h00_0000, 2'h1, 8'h01}, 4'h3);
    apb(1'b0, psmc_pkg::MODE_SEL_ADDR, 32'h0000_0000, 4'h0);
    check(d, 32'h0000_0000);
  endtask : t_mode
  task automatic t_protect();
    apb(1'b1, psmc_pkg::POWER_CTRL_ADDR, 32'h0000_0200, 4'h2);
    repeat (4) @(posedge pclk);
    check(gates(), 32'h0000_000f);
    apb(1'b1, psmc_pkg::UNLOCK_CMD_ADDR, 32'h0000_0011, 4'h1);
    apb(1'b1, psmc_pkg::MODE_SEL_ADDR, 32'h0000_0000, 4'h1);
    apb(1'b1, psmc_pkg::POWER_CTRL_ADDR, 32'h0000_0200, 4'h2);
    repeat (4) @(posedge pclk);
    check(gates(), 32'h0000_000f);
  endtask : t_protect
  task automatic t_idle();
    prot(8'hff, 8'h02);
    check(gates(), 32'h0000_000c);
    wake(1'b0);
    check(gates(), 32'h0000_000f);
    apb(1'b0, psmc_pkg::POWER_CTRL_ADDR, 32'h0000_0000, 4'h0);
    check({31'h0, d[9]}, 32'h0000_0000);
  endtask : t_idle
  task automatic t_stop();
    apb(1'b1, psmc_pkg::MODE_SEL_ADDR, 32'h0000_0001, 4'h1);
    prot(8'h00, 8'h20);
    check(gates(), 32'h0000_000f);
    prot(8'h3c, 8'h22);
    check(gates(), 32'h0000_0000);
    nmi_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    nmi_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    check(gates(), 32'h0000_0000);
    apb(1'b0, psmc_pkg::STATUS_ADDR, 32'h0000_0000, 4'h0);
    check(d, 32'h0000_0002);
    wake(1'b0);
    check({31'h0, n >= 16384 && n <= 16400}, 32'h0000_0001);
    prot(8'h80, 8'h02);
    wake(1'b1);
    check({31'h0, n >= 16384 && n <= 16400}, 32'h0000_0001);
  endtask : t_stop
  task automatic t_halt();
    halt_req <= 1'b1;
    repeat (8) @(posedge pclk);
    check(gates(), 32'h0000_000e);
    halt_req <= 1'b0;
    repeat (8) @(posedge pclk);
    check(gates(), 32'h0000_000f);
    ext_clock <= 1'b1;
    repeat (4) @(posedge pclk);
    check(gates(), 32'h0000_0007);
    ext_clock <= 1'b0;
    repeat (4) @(posedge pclk);
    check(gates(), 32'h0000_000f);
  endtask : t_halt
  task automatic t_direct();
    presetn     <= 1'b0;
    direct_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn     <= 1'b1;
    repeat (3) @(posedge pclk);
    check(gates(), 32'h0000_0003);
    apb(1'b1, psmc_pkg::MODE_SEL_ADDR, 32'h0000_0001, 4'h1);
    prot(8'h42, 8'h02);
    check(gates(), 32'h0000_0000);
    wake(1'b0);
    check({31'h0, n >= 16384 && n <= 16400}, 32'h0000_0001);
  endtask : t_direct
  task automatic end_of_test();
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, direct_mode, ext_clock} = 6'h00;
    {halt_req, nmi_pin, irq_wake, paddr, pwdata, pstrb} = 0;
    err_count  = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check(gates(), 32'h0000_000f);
    t_mode();
    t_protect();
    t_idle();
    t_stop();
    t_halt();
    t_direct();
    end_of_test();
  end
endmodule : tb
bind psmc_top psmc_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .direct_mode(direct_mode), .ext_clock(ext_clock), .halt_req(halt_req),
  .osc_en(osc_en), .pll_en(pll_en), .periph_clk_en(periph_clk_en),
  .cpu_clk_en(cpu_clk_en), .exec_hold(exec_hold));
